/* File: common/lcg_cfg.svh */
// Register offsets, field positions, reset values and fixed positions of the cell group.
`ifndef LCG_CFG_SVH
`define LCG_CFG_SVH

`define LCG_CELLS 10
`define LCG_TAP_LOW 3
`define LCG_TAP_HIGH 9
`define LCG_GROUP_STEP 2

`define LCG_CTRL_OFS 8'h00
`define LCG_LUT_OFS 8'h04
`define LCG_STATUS_OFS 8'h08
`define LCG_CHAIN_OFS 8'h0C

`define LCG_F_MODE 1:0
`define LCG_F_STORE 3:2
`define LCG_F_CARRYLUT 4
`define LCG_F_PACK 5
`define LCG_F_SELA 6
`define LCG_F_SELB 7
`define LCG_F_CELLCE 8
`define LCG_F_CESEL 9
`define LCG_F_DEVRST 10
`define LCG_F_PRESET 11
`define LCG_F_LINK 12
`define LCG_F_COUNT 13
`define LCG_F_TAP4 14
`define LCG_F_START 3:0

`define LCG_CTRL_MASK 32'h0000_7FFF
`define LCG_LUT_MASK 32'h0000_FFFF
`define LCG_CHAIN_MASK 32'h0000_000F
`define LCG_CTRL_RST 32'h0000_0000
`define LCG_LUT_RST 32'h0000_0000
`define LCG_CHAIN_RST 32'h0000_000F

`define LCG_RESP_OKAY 2'b00
`define LCG_RESP_SLVERR 2'b10

`endif

/* File: common/lcg_pkg.sv */
// Types shared by the cell group: operating modes and storage element kinds.
`default_nettype none
package lcg_pkg;
    typedef enum logic [1:0] {
        LCG_NORMAL = 2'b00,
        LCG_ARITH = 2'b01,
        LCG_MULT = 2'b10
    } lcg_mode_e;
    typedef enum logic [1:0] {
        LCG_ST_D = 2'b00,
        LCG_ST_T = 2'b01,
        LCG_ST_JK = 2'b10,
        LCG_ST_SR = 2'b11
    } lcg_store_e;
endpackage
`default_nettype wire

/* File: hdl/lcg_cell_group.sv */
// Ten-cell logic group with carry-select chains, storage elements and a register slave.
//
// What this block does
// - Group carry output comes only from cell four and/or cell ten.
// - The neighbour link from the previous cell enters through the fourth data input.
// - Each storage element works as D, T, JK or SR flip-flop.
// - Combinational use bypasses the storage element; lookup result drives outputs.
// - Two outputs, each independently lookup result or storage value.
// - Exactly one mode at a time: general logic, arithmetic or multiplier.
// - Logic and arithmetic modes take group clock, enable, async and sync controls.
// - Logic mode lookup uses three data inputs plus carry or third input.
// - Carry into the lookup forbids an unrelated packed storage function.
// - Two group clock enables plus one clock enable per cell.
// - Arithmetic mode forms two sums and two carries for carry zero and one.
// - Group carry picks a chain; that chain's level picks the sum.
// - Zero-chain carry in steers zero-chain out; one-chain likewise.
// - Adder output equals first plus second input plus selected carry.
// - Counter enable and up/down come from local data inputs.
// - Synchronous clear and load act on every storage element.
// - A carry chain may start at any cell position.
// - Long chains continue into the next group of same parity.
// - Multiplier cell sums two cross partial products in one stage.
// - Multiplier sum controls use group enable one and preset/load resource.
// - Multiplier carries pass vertically between groups of one column.
// - Multiplier gives its sum, plain or registered, with both chain carries.
// - Asynchronous clear beats preset or asynchronous load.
// - Group clock enable one is unused as enable in multiplier mode.
// - Enabled device-wide reset clears every storage element above all else.
`timescale 1ns/1ps
`default_nettype none
`include "lcg_cfg.svh"

module lcg_cell_group #(
    parameter int ADDR_W = 8,
    parameter int GROUP_INDEX = 0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] firstDataInput,
    input wire logic [9:0] secondDataInput,
    input wire logic [9:0] thirdDataInput,
    input wire logic [9:0] fourthDataInput,
    input wire logic neighbourLinkIn,
    input wire logic groupCarryIn,
    input wire logic zeroChainCarryIn,
    input wire logic oneChainCarryIn,
    input wire logic verticalZeroCarryIn,
    input wire logic verticalOneCarryIn,
    input wire logic groupClockEnableOne,
    input wire logic groupClockEnableTwo,
    input wire logic [9:0] cellClockEnable,
    input wire logic asyncClear,
    input wire logic groupPresetOrAsyncLoad,
    input wire logic syncClear,
    input wire logic syncLoad,
    input wire logic deviceWideResetN,
    output logic [9:0] cellOutA_r,
    output logic [9:0] cellOutB_r,
    output logic groupCarryOut_r,
    output logic zeroChainCarryOut_r,
    output logic oneChainCarryOut_r,
    output logic verticalZeroCarryOut_r,
    output logic verticalOneCarryOut_r,
    output logic [7:0] nextChainGroup_r
);
    import lcg_pkg::*;

    // ----------------------------------------
    // Register decode helpers
    // ----------------------------------------

    // Maps a byte address to {hit, index}; index 0 ctrl, 1 lut, 2 status, 3 chain.
    function automatic logic [2:0] lcgDecode(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'b000;
        if (a == ADDR_W'(`LCG_CTRL_OFS)) begin
            r = 3'b100;
        end else if (a == ADDR_W'(`LCG_LUT_OFS)) begin
            r = 3'b101;
        end else if (a == ADDR_W'(`LCG_STATUS_OFS)) begin
            r = 3'b110;
        end else if (a == ADDR_W'(`LCG_CHAIN_OFS)) begin
            r = 3'b111;
        end
        return r;
    endfunction

    // Merges write data into an old word lane by lane under the byte strobes.
    function automatic logic [31:0] lcgMerge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Next state of one storage element for its configured kind.
    function automatic logic lcgNextQ(input lcg_store_e t, input logic q, input logic d,
                                      input logic k);
        logic r;
        r = q;
        case (t)
            LCG_ST_D: r = d;
            LCG_ST_T: r = q ^ d;
            LCG_ST_JK: r = (d & ~q) | (~k & q);
            LCG_ST_SR: r = k ? 1'b0 : (d ? 1'b1 : q);
            default: r = q;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Configuration registers and bus state
    // ----------------------------------------
    logic [31:0] ctrlR;
    logic [31:0] lutR;
    logic [31:0] chainR;
    logic [ADDR_W-1:0] awAddrR;
    logic awHeldR;
    logic [31:0] wDataR;
    logic [3:0] wStrbR;
    logic wHeldR;
    logic devSync1_r;
    logic devSync2_r;
    logic devSync3_r;
    logic devPin_r;
    logic [9:0] qR;

    // Configuration fields as named wires.
    wire lcg_mode_e modeSel = lcg_mode_e'(ctrlR[`LCG_F_MODE]);
    wire lcg_store_e storeSel = lcg_store_e'(ctrlR[`LCG_F_STORE]);
    wire isMult = (modeSel == LCG_MULT);
    wire isArith = (modeSel == LCG_ARITH);
    wire isNorm = !isMult && !isArith;
    wire carryLut = ctrlR[`LCG_F_CARRYLUT];
    wire packOn = ctrlR[`LCG_F_PACK] && !carryLut;
    wire selA = ctrlR[`LCG_F_SELA];
    wire selB = ctrlR[`LCG_F_SELB];
    wire countOn = isArith && ctrlR[`LCG_F_COUNT];
    wire [3:0] chainStart = chainR[`LCG_F_START];

    // Group-wide controls; preset and load are borrowed by the multiplier.
    wire devClr = ctrlR[`LCG_F_DEVRST] && !devPin_r;
    wire asyncSet = groupPresetOrAsyncLoad && !isMult;
    wire ceGroup = isMult ? groupClockEnableTwo :
        (ctrlR[`LCG_F_CESEL] ? groupClockEnableTwo : groupClockEnableOne);
    wire ppEnable = groupClockEnableOne;
    wire ppInvert = groupPresetOrAsyncLoad;

    // ----------------------------------------
    // Cells and carry-select chains
    // ----------------------------------------
    logic [10:0] chain0;
    logic [10:0] chain1;
    logic [9:0] selCarry;
    logic [9:0] lutOut;
    logic [9:0] combOut;
    logic [9:0] qNxt;

    // Multiplier carries arrive from the group above, others from the row.
    assign chain0[0] = isMult ? verticalZeroCarryIn : zeroChainCarryIn;
    assign chain1[0] = isMult ? verticalOneCarryIn : oneChainCarryIn;

    // One slice per cell: lookup, parallel sums, chain carries and next state.
    for (genvar i = 0; i < `LCG_CELLS; i++) begin : g_cell
        wire startHere = (chainStart == 4'(i));
        wire cin0 = startHere ? 1'b0 : chain0[i];
        wire cin1 = startHere ? 1'b1 : chain1[i];
        wire ppOne = firstDataInput[i] & fourthDataInput[i] & ppEnable;
        wire ppTwo = (secondDataInput[i] & thirdDataInput[i] & ppEnable) ^ ppInvert;
        wire opA = isMult ? ppOne : (countOn ? qR[i] : firstDataInput[i]);
        wire opB = isMult ? ppTwo : (countOn ? thirdDataInput[i] : secondDataInput[i]);
        wire sumZero = opA ^ opB;
        wire sumOne = ~(opA ^ opB);
        wire linkIn;
        wire lutThird = carryLut ? selCarry[i] : thirdDataInput[i];
        wire lutFourth = ctrlR[`LCG_F_LINK] ? linkIn : fourthDataInput[i];
        wire dIn = (isNorm && packOn) ? thirdDataInput[i] : combOut[i];
        wire cellCe = ctrlR[`LCG_F_CELLCE] ? cellClockEnable[i] : 1'b1;
        wire countEn = countOn ? fourthDataInput[i] : 1'b1;
        wire loadVal = ctrlR[`LCG_F_PRESET] ? 1'b1 : thirdDataInput[i];
        if (i == 0) begin : g_first
            assign linkIn = neighbourLinkIn;
        end else begin : g_rest
            assign linkIn = lutOut[i-1];
        end
        assign chain0[i+1] = cin0 ? (opA | opB) : (opA & opB);
        assign chain1[i+1] = cin1 ? (opA | opB) : (opA & opB);
        assign selCarry[i] = groupCarryIn ? cin1 : cin0;
        assign lutOut[i] = lutR[{lutFourth, lutThird, secondDataInput[i], firstDataInput[i]}];
        assign combOut[i] = isNorm ? lutOut[i] : (selCarry[i] ? sumOne : sumZero);
        assign qNxt[i] = devClr ? 1'b0 :
            asyncClear ? 1'b0 :
            asyncSet ? loadVal :
            syncClear ? 1'b0 :
            syncLoad ? thirdDataInput[i] :
            (ceGroup && cellCe && countEn) ?
            lcgNextQ(storeSel, qR[i], dIn, fourthDataInput[i]) : qR[i];
    end

    // Group carry out taken from cell four or cell ten only.
    wire carryTap = ctrlR[`LCG_F_TAP4] ?
        (groupCarryIn ? chain1[`LCG_TAP_LOW+1] : chain0[`LCG_TAP_LOW+1]) :
        (groupCarryIn ? chain1[`LCG_TAP_HIGH+1] : chain0[`LCG_TAP_HIGH+1]);
    wire packConflict = carryLut && ctrlR[`LCG_F_PACK];

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [2:0] rdHit = lcgDecode(s_axi_araddr);
    wire [2:0] wrHit = lcgDecode(awAddrR);
    wire [31:0] statusWord = {18'h0_0000, ctrlR[`LCG_F_MODE], groupCarryOut_r, packConflict, qR};
    wire [31:0] rdWord = (rdHit == 3'b100) ? ctrlR :
        (rdHit == 3'b101) ? lutR :
        (rdHit == 3'b110) ? statusWord :
        (rdHit == 3'b111) ? chainR : 32'h0000_0000;

    // Storage elements of the ten cells; the group clock is clk_sys.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            qR <= 10'h000;
        end else if (clkEn) begin
            qR <= qNxt;
        end
    end

    // Registered cell outputs; each port picks lookup result or stored value.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cellOutA_r <= 10'h000;
            cellOutB_r <= 10'h000;
        end else if (clkEn) begin
            cellOutA_r <= selA ? qNxt : combOut;
            cellOutB_r <= selB ? qNxt : combOut;
        end
    end

    // Registered chain outputs toward the next group of the same parity or column.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            groupCarryOut_r <= 1'b0;
            zeroChainCarryOut_r <= 1'b0;
            oneChainCarryOut_r <= 1'b0;
            verticalZeroCarryOut_r <= 1'b0;
            verticalOneCarryOut_r <= 1'b0;
            nextChainGroup_r <= 8'h00;
        end else if (clkEn) begin
            groupCarryOut_r <= carryTap;
            zeroChainCarryOut_r <= isMult ? 1'b0 : chain0[`LCG_CELLS];
            oneChainCarryOut_r <= isMult ? 1'b0 : chain1[`LCG_CELLS];
            verticalZeroCarryOut_r <= isMult ? chain0[`LCG_CELLS] : 1'b0;
            verticalOneCarryOut_r <= isMult ? chain1[`LCG_CELLS] : 1'b0;
            nextChainGroup_r <= 8'(GROUP_INDEX + `LCG_GROUP_STEP);
        end
    end

    // Device-wide reset pin passes three flops; a change counts once two agree.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            devSync1_r <= 1'b1;
            devSync2_r <= 1'b1;
            devSync3_r <= 1'b1;
            devPin_r <= 1'b1;
        end else if (clkEn) begin
            devSync1_r <= deviceWideResetN;
            devSync2_r <= devSync1_r;
            devSync3_r <= devSync2_r;
            if (devSync2_r == devSync3_r) begin
                devPin_r <= devSync3_r;
            end
        end
    end

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------

    // Write channel: address and data taken in either order, answer after both.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LCG_RESP_OKAY;
            awAddrR <= '0;
            awHeldR <= 1'b0;
            wDataR <= 32'h0000_0000;
            wStrbR <= 4'h0;
            wHeldR <= 1'b0;
            ctrlR <= `LCG_CTRL_RST;
            lutR <= `LCG_LUT_RST;
            chainR <= `LCG_CHAIN_RST;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrR <= s_axi_awaddr;
                awHeldR <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataR <= s_axi_wdata;
                wStrbR <= s_axi_wstrb;
                wHeldR <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (awHeldR && wHeldR && !s_axi_bvalid) begin
                awHeldR <= 1'b0;
                wHeldR <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit[2] ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
                if (wrHit == 3'b100) begin
                    ctrlR <= lcgMerge(ctrlR, wDataR, wStrbR) & `LCG_CTRL_MASK;
                end else if (wrHit == 3'b101) begin
                    lutR <= lcgMerge(lutR, wDataR, wStrbR) & `LCG_LUT_MASK;
                end else if (wrHit == 3'b111) begin
                    chainR <= lcgMerge(chainR, wDataR, wStrbR) & `LCG_CHAIN_MASK;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, data one edge after the address.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LCG_RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdHit[2] ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------

    // Clear wins over preset or load in the same cycle.
    property p_aclr_wins;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && asyncClear && groupPresetOrAsyncLoad |=> qR == 10'h000;
    endproperty
    a_aclr_wins: assert property (p_aclr_wins) else $error("Clear lost to preset.");

    // An enabled device-wide reset empties every cell.
    property p_dev_reset;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && devClr |=> qR == 10'h000;
    endproperty
    a_dev_reset: assert property (p_dev_reset) else $error("Device reset ignored.");

    // Lookup result reaches port A when it is set to combinational.
    property p_comb_out;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && isNorm && !selA |=> cellOutA_r[0] == $past(lutOut[0]);
    endproperty
    a_comb_out: assert property (p_comb_out) else $error("Lookup not on port A.");

    // Equal carries into both chains give equal chain outputs.
    property p_chain_pair;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && !isMult && chainStart == 4'hF && zeroChainCarryIn == oneChainCarryIn
        |=> zeroChainCarryOut_r == oneChainCarryOut_r;
    endproperty
    a_chain_pair: assert property (p_chain_pair) else $error("Chains diverged.");

    // Group enable one does not clock cells in multiplier mode.
    property p_mult_ce;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && isMult && !groupClockEnableTwo && !asyncClear && !syncClear && !syncLoad
        && !devClr |=> $stable(qR);
    endproperty
    a_mult_ce: assert property (p_mult_ce) else $error("Enable one clocked a cell.");

    // A fresh chain at cell one adds the first two inputs with carry zero.
    property p_adder;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && isArith && !countOn && chainStart == 4'h0 && !groupCarryIn && !selA
        |=> cellOutA_r[0] == $past(firstDataInput[0] ^ secondDataInput[0]);
    endproperty
    a_adder: assert property (p_adder) else $error("Adder sum wrong.");

    // Synchronous clear empties every cell of the group.
    property p_sync_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && syncClear && !groupPresetOrAsyncLoad |=> qR == 10'h000;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("Sync clear missed.");

    // Disabled partial products give a zero sum on every cell.
    property p_mult_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        clkEn && isMult && !groupClockEnableOne && !groupPresetOrAsyncLoad
        && chainStart == 4'h0 && !groupCarryIn && !selA |=> cellOutA_r == 10'h000;
    endproperty
    a_mult_zero: assert property (p_mult_zero) else $error("Product sum not zero.");
endmodule
`default_nettype wire

/* File: tb/lcg_cell_group_bench.sv */
// Self-checking bench for the ten-cell logic group.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module lcg_cell_group_bench;
    logic clk_sys, rst_n, awV, wV, bR, arV, rR, ci, z0, o1, ce1, ac, pre, sc, sl, dr;
    logic [7:0] awA, arA, ncg;
    logic [31:0] wD, rd;
    logic [1:0] rs;
    logic [9:0] d1, d2, d3, d4, outA, outB;
    logic awR, wR, bV, arR, rV, gco, zco, oco, vzo, voo;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    int error_cnt = 0;
    int tests_run = 0;

    // ----------------------------------------
    // Design under test and clock
    // ----------------------------------------
    lcg_cell_group uut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1),
        .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
        .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
        .s_axi_arready(arR), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
        .s_axi_rready(rR), .firstDataInput(d1), .secondDataInput(d2),
        .thirdDataInput(d3), .fourthDataInput(d4), .neighbourLinkIn(1'b0),
        .groupCarryIn(ci), .zeroChainCarryIn(z0), .oneChainCarryIn(o1),
        .verticalZeroCarryIn(1'b0), .verticalOneCarryIn(1'b0), .groupClockEnableOne(ce1),
        .groupClockEnableTwo(ce1), .cellClockEnable({10{ce1}}), .asyncClear(ac),
        .groupPresetOrAsyncLoad(pre), .syncClear(sc), .syncLoad(sl),
        .deviceWideResetN(dr), .cellOutA_r(outA), .cellOutB_r(outB), .groupCarryOut_r(gco),
        .zeroChainCarryOut_r(zco), .oneChainCarryOut_r(oco), .verticalZeroCarryOut_r(vzo),
        .verticalOneCarryOut_r(voo), .nextChainGroup_r(ncg));

    // The clock toggles every half period of 10 ns.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compares two values and counts the result.
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A used-up wait bound counts as a mismatch and closes the run.
    task automatic tmo(input int n);
        if (n >= 50) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, n, 0);
            give_verdict();
        end
    endtask

    // Lets a number of rising edges pass.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One write; each channel is released at its own handshake edge.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ga, gw;
        n = 0;
        ga = 1'b0;
        gw = 1'b0;
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        while (!(ga && gw) && n < 50) begin
            @(posedge clk_sys);
            n++;
            if (!ga && awR) begin
                ga = 1'b1;
                awV <= 1'b0;
            end
            if (!gw && wR) begin
                gw = 1'b1;
                wV <= 1'b0;
            end
        end
        bR <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!bV && n < 50);
        r = bResp;
        bR <= 1'b0;
        tmo(n);
    endtask

    // One read; data and response are taken at the rvalid edge.
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        arA <= a;
        arV <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!arR && n < 50);
        arV <= 1'b0;
        rR <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!rV && n < 50);
        d = rData;
        r = rResp;
        rR <= 1'b0;
        tmo(n);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, write masking and an unmapped address.
    task automatic t_regs;
        axr(8'h00, rd, rs);
        `CHK(rd, 32'h0000_0000);
        axr(8'h0C, rd, rs);
        `CHK(rd, 32'h0000_000F);
        axr(8'h10, rd, rs);
        `CHK(rs, 2'b10);
        axw(8'h04, 32'hFFFF_8888, rs);
        `CHK(rs, 2'b00);
        axr(8'h04, rd, rs);
        `CHK(rd, 32'h0000_8888);
        `CHK(ncg, 8'h02);
        $display("test regs done");
    endtask

    // Lookup on one output, stored value on the other, clear over load.
    task automatic t_logic;
        axw(8'h00, 32'h0000_0080, rs);
        d1 <= 10'h3FF;
        d2 <= 10'h155;
        d3 <= 10'h3FF;
        ce1 <= 1'b1;
        cyc(4);
        `CHK(outA, 10'h155);
        `CHK(outB, 10'h155);
        ac <= 1'b1;
        pre <= 1'b1;
        cyc(4);
        `CHK(outB, 10'h000);
        `CHK(outA, 10'h155);
        ac <= 1'b0;
        pre <= 1'b0;
        d3 <= 10'h2AA;
        sl <= 1'b1;
        cyc(4);
        `CHK(outB, 10'h2AA);
        sl <= 1'b0;
        sc <= 1'b1;
        cyc(4);
        `CHK(outB, 10'h000);
        sc <= 1'b0;
        axw(8'h00, 32'h0000_0480, rs);
        dr <= 1'b0;
        cyc(6);
        `CHK(outB, 10'h000);
        dr <= 1'b1;
        cyc(6);
        $display("test logic done");
    endtask

    // Carry-select adder with both chains and a full ripple.
    task automatic t_arith;
        axw(8'h00, 32'h0000_0081, rs);
        d1 <= 10'h001;
        d2 <= 10'h001;
        cyc(4);
        `CHK(outA, 10'h002);
        d1 <= 10'h3FF;
        d2 <= 10'h3FF;
        cyc(4);
        `CHK(outA, 10'h3FE);
        `CHK(zco, 1'b1);
        `CHK(oco, 1'b1);
        d1 <= 10'h000;
        d2 <= 10'h000;
        ci <= 1'b1;
        o1 <= 1'b1;
        cyc(4);
        `CHK(outA, 10'h001);
        ci <= 1'b0;
        o1 <= 1'b0;
        $display("test arith done");
    endtask

    // Group carry from cell four versus cell ten.
    task automatic t_tap;
        axw(8'h00, 32'h0000_4001, rs);
        axw(8'h0C, 32'h0000_0000, rs);
        z0 <= 1'b1;
        d1 <= 10'h00F;
        d2 <= 10'h00F;
        cyc(4);
        `CHK(gco, 1'b1);
        `CHK(outA, 10'h01E);
        z0 <= 1'b0;
        axw(8'h00, 32'h0000_0001, rs);
        cyc(4);
        `CHK(gco, 1'b0);
        $display("test tap done");
    endtask

    // Multiplier cells: cross products, vertical chain and the borrowed controls.
    task automatic t_mult;
        axw(8'h00, 32'h0000_0002, rs);
        {d1, d2, d3, d4} <= {4{10'h3FF}};
        cyc(4);
        `CHK(outA, 10'h3FE);
        `CHK(vzo, 1'b1);
        `CHK(voo, 1'b1);
        `CHK(zco, 1'b0);
        ce1 <= 1'b0;
        cyc(4);
        `CHK(outA, 10'h000);
        pre <= 1'b1;
        cyc(4);
        `CHK(outA, 10'h3FF);
        pre <= 1'b0;
        ce1 <= 1'b1;
        $display("test mult done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    // Drives every input at time zero, resets, then runs the scenarios.
    initial begin
        {rst_n, awV, wV, bR, arV, rR, ci, z0, o1, ce1, ac, pre, sc, sl} = '0;
        dr = 1'b1;
        awA = 8'h00;
        arA = 8'h00;
        wD = 32'h0000_0000;
        {d1, d2, d3, d4} = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_logic();
        t_arith();
        t_tap();
        t_mult();
        give_verdict();
    end
endmodule
`default_nettype wire
